// *** logic/rtd_top.sv ***
// dual-channel ring trip detection with AHB-Lite register slave
// assumes one clock, loop current samples synchronous to hclk
// and a line feed state supplied by the line feed controller
`timescale 1ns/1ps
module rtd_top #(
   parameter int unsigned TICK_CYCLES = rtd_pkg::TICK_CYCLES,
   parameter bit          EXT_RING    = 1'b1   // external ringing variant
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // ahb-lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   // per channel loop side
   input  wire logic [1:0][15:0]  loop_current_sense,
   input  wire logic [1:0]        sample_valid,
   input  wire logic [1:0][2:0]   line_state,
   output logic                   trip_irq,
   output logic      [1:0]        closure_masked,
   output logic      [1:0][15:0]  ringing_dc_offset,
   output logic                   test_relay_one_a,
   output logic                   test_relay_one_b,
   output logic                   test_relay_two_a,
   output logic                   test_relay_two_b,
   output logic                   ringing_relay_drive_a,
   output logic                   ringing_relay_drive_b
);
   // ---------------------------------------------------------------
   // bus state
   // ---------------------------------------------------------------
   logic        wr_pend_q;   // write data phase pending
   logic        rd_pend_q;   // read wait state pending
   logic        ch_q;        // channel of pending access
   logic [3:0]  idx_q;       // register index of pending access
   logic        map_q;       // pending access hits a register
   logic        addr_ok;     // live address phase accepted
   logic        hit;         // live address maps to a register
   logic [31:0] rd_mux;      // read value of pending access
   logic        tick;        // 1.25 ms enable

   // ---------------------------------------------------------------
   // per channel registers
   // ---------------------------------------------------------------
   logic [1:0][15:0] ac_th_q;     // ac_trip_threshold
   logic [1:0][15:0] dc_th_q;     // dc_trip_threshold
   logic [1:0][15:0] period_q;    // trip_sample_period
   logic [1:0][15:0] ac_db_q;     // ac_trip_debounce
   logic [1:0][15:0] dc_db_q;     // dc_trip_debounce
   logic [1:0][15:0] sense_q;     // last sample seen
   logic [1:0][7:0]  mask_q;      // closure_mask_time
   logic [1:0][2:0]  shd_q;       // line_state_shadow
   logic [1:0]       trip_q;      // trip_detected
   logic [1:0]       pend_q;      // trip_irq_pending
   logic [1:0]       en_q;        // trip_irq_enable
   logic [1:0][2:0]  relay_q;     // relay drive bits
   logic [1:0][7:0]  mcnt_q;      // mask ticks left
   logic [1:0]       ring_q;      // ringing last cycle
   logic [1:0]       ring;        // ringing now
   logic [1:0]       ac_trip;     // debounced ac path
   logic [1:0]       dc_trip;     // debounced dc path
   logic [1:0]       wr_ch;       // write strobe per channel

   // ---------------------------------------------------------------
   // address phase decode
   // ---------------------------------------------------------------
   // only word registers exist; hsize is accepted but not checked
   assign addr_ok = hsel && hready && htrans[1];
   assign hit     = (haddr[31:7] == 25'h000_0000) && (haddr[5:2] <= rtd_pkg::IDX_RELAY);

   // a read takes one wait state so that it always sees the result
   // of a write whose data phase ends at the same edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         ch_q      <= 1'b0;
         idx_q     <= 4'h0;
         map_q     <= 1'b0;
      end else begin
         if (rd_pend_q) begin
            rd_pend_q <= 1'b0;                 // wait state over
         end else begin
            rd_pend_q <= addr_ok && !hwrite;
         end
         wr_pend_q <= addr_ok && hwrite && !rd_pend_q;
         if (addr_ok && !rd_pend_q) begin
            ch_q  <= haddr[rtd_pkg::CH_BIT];
            idx_q <= haddr[5:2];
            map_q <= hit;
         end
      end
   end

   // ---------------------------------------------------------------
   // bus answer: ready drops for the read wait state, always okay
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
      end else begin
         hreadyout <= !(addr_ok && !hwrite && !rd_pend_q);
         hresp     <= 1'b0;
         if (rd_pend_q) begin
            hrdata <= rd_mux;
         end
      end
   end

   // ---------------------------------------------------------------
   // read multiplexer; unmapped addresses read as zero
   // ---------------------------------------------------------------
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (map_q) begin
         case (idx_q)
            rtd_pkg::IDX_AC_TH:  rd_mux[15:0] = ac_th_q[ch_q];
            rtd_pkg::IDX_DC_TH:  rd_mux[15:0] = dc_th_q[ch_q];
            rtd_pkg::IDX_PERIOD: rd_mux[15:0] = period_q[ch_q];
            rtd_pkg::IDX_AC_DB:  rd_mux[15:0] = ac_db_q[ch_q];
            rtd_pkg::IDX_DC_DB:  rd_mux[15:0] = dc_db_q[ch_q];
            rtd_pkg::IDX_SENSE:  rd_mux[15:0] = sense_q[ch_q];
            rtd_pkg::IDX_MASK:   rd_mux[7:0]  = mask_q[ch_q];
            rtd_pkg::IDX_OFFSET: rd_mux[15:0] = ringing_dc_offset[ch_q];
            rtd_pkg::IDX_STATUS: begin
               rd_mux[rtd_pkg::STS_TRIP] = trip_q[ch_q];
               rd_mux[rtd_pkg::STS_SHADOW +: 3] = shd_q[ch_q];
            end
            rtd_pkg::IDX_IRQVEC: rd_mux[rtd_pkg::IRQ_TRIP] = pend_q[ch_q];
            rtd_pkg::IDX_IRQEN:  rd_mux[rtd_pkg::IRQ_TRIP] = en_q[ch_q];
            rtd_pkg::IDX_RELAY:  rd_mux[2:0]  = relay_q[ch_q];
            default:             rd_mux = 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // 1.25 ms timebase shared by debounce and closure mask
   // ---------------------------------------------------------------
   rtd_tick #(
      .CYCLES  (TICK_CYCLES)
   ) u_tick (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tick_q  (tick)
   );

   // ---------------------------------------------------------------
   // channels
   // ---------------------------------------------------------------
   for (genvar c = 0; c < 2; c++) begin : g_ch
      rtd_pkg::rtd_path_cfg_s ac_cfg;   // ac path settings
      rtd_pkg::rtd_path_cfg_s dc_cfg;   // dc path settings

      assign wr_ch[c] = wr_pend_q && map_q && (ch_q == 1'(c));
      assign ring[c]  = line_state[c] == rtd_pkg::LFS_RING;
      assign ac_cfg   = '{threshold: ac_th_q[c], period: period_q[c], debounce: ac_db_q[c]};
      assign dc_cfg   = '{threshold: dc_th_q[c], period: period_q[c], debounce: dc_db_q[c]};

      // writable settings of this channel
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            ac_th_q[c]           <= rtd_pkg::RST_TH;
            dc_th_q[c]           <= rtd_pkg::RST_TH;
            period_q[c]          <= rtd_pkg::RST_PERIOD;
            ac_db_q[c]           <= rtd_pkg::RST_DB;
            dc_db_q[c]           <= rtd_pkg::RST_DB;
            mask_q[c]            <= rtd_pkg::RST_MASK;
            ringing_dc_offset[c] <= rtd_pkg::RST_OFFSET;
            en_q[c]              <= 1'b0;
            relay_q[c]           <= 3'h0;
         end else if (wr_ch[c]) begin
            case (idx_q)
               rtd_pkg::IDX_AC_TH:  ac_th_q[c]  <= hwdata[15:0];
               rtd_pkg::IDX_DC_TH:  dc_th_q[c]  <= hwdata[15:0];
               rtd_pkg::IDX_PERIOD: period_q[c] <= hwdata[15:0];
               rtd_pkg::IDX_AC_DB:  ac_db_q[c]  <= hwdata[15:0];
               rtd_pkg::IDX_DC_DB:  dc_db_q[c]  <= hwdata[15:0];
               rtd_pkg::IDX_MASK:   mask_q[c]   <= hwdata[7:0];
               rtd_pkg::IDX_OFFSET: begin
                  // codes beyond full offset are clamped, not wrapped
                  if (hwdata[15:0] > rtd_pkg::OFFSET_MAX) begin
                     ringing_dc_offset[c] <= rtd_pkg::OFFSET_MAX;
                  end else begin
                     ringing_dc_offset[c] <= hwdata[15:0];
                  end
               end
               rtd_pkg::IDX_IRQEN:  en_q[c] <= hwdata[rtd_pkg::IRQ_TRIP];
               rtd_pkg::IDX_RELAY: begin
                  relay_q[c][rtd_pkg::RLY_T1] <= hwdata[rtd_pkg::RLY_T1];
                  relay_q[c][rtd_pkg::RLY_T2] <= hwdata[rtd_pkg::RLY_T2];
                  // ringing relay stays off without external ringing
                  relay_q[c][rtd_pkg::RLY_RING] <= EXT_RING & hwdata[rtd_pkg::RLY_RING];
               end
               default: ;   // read-only, or irq vector cleared below: ignored here
            endcase
         end
      end

      // monitor copies of the line side
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            shd_q[c]   <= 3'h0;
            sense_q[c] <= 16'h0000;
         end else begin
            shd_q[c] <= line_state[c];
            if (sample_valid[c]) begin
               sense_q[c] <= loop_current_sense[c];
            end
         end
      end

      // ac path rectifies; dc path sees raw samples, which is also
      // the chain used for the external ringing feed
      rtd_path u_ac (
         .hclk    (hclk),
         .hresetn (hresetn),
         .run     (ring[c]),
         .smp_vld (sample_valid[c]),
         .smp     (loop_current_sense[c]),
         .rectify (1'b1),
         .cfg     (ac_cfg),
         .tick    (tick),
         .trip_q  (ac_trip[c])
      );
      rtd_path u_dc (
         .hclk    (hclk),
         .hresetn (hresetn),
         .run     (ring[c]),
         .smp_vld (sample_valid[c]),
         .smp     (loop_current_sense[c]),
         .rectify (1'b0),
         .cfg     (dc_cfg),
         .tick    (tick),
         .trip_q  (dc_trip[c])
      );

      // trip status and sticky pending; a new trip beats a clear
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            trip_q[c] <= 1'b0;
            pend_q[c] <= 1'b0;
         end else begin
            trip_q[c] <= ac_trip[c] | dc_trip[c];
            if ((ac_trip[c] | dc_trip[c]) && !trip_q[c]) begin
               pend_q[c] <= 1'b1;
            end else if (wr_ch[c] && idx_q == rtd_pkg::IDX_IRQVEC
                         && hwdata[rtd_pkg::IRQ_TRIP]) begin
               pend_q[c] <= 1'b0;
            end
         end
      end

      // loop closure mask armed on the way out of ringing
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            ring_q[c]         <= 1'b0;
            mcnt_q[c]         <= 8'h00;
            closure_masked[c] <= 1'b0;
         end else begin
            ring_q[c] <= ring[c];
            if (ring_q[c] && !ring[c]) begin
               mcnt_q[c]         <= mask_q[c];
               closure_masked[c] <= mask_q[c] != 8'h00;
            end else if (tick && mcnt_q[c] != 8'h00) begin
               mcnt_q[c] <= mcnt_q[c] - 8'h01;
               if (mcnt_q[c] == 8'h01) begin
                  closure_masked[c] <= 1'b0;
               end
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // combined interrupt and relay drive pins, all registered
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trip_irq              <= 1'b0;
         test_relay_one_a      <= 1'b0;
         test_relay_one_b      <= 1'b0;
         test_relay_two_a      <= 1'b0;
         test_relay_two_b      <= 1'b0;
         ringing_relay_drive_a <= 1'b0;
         ringing_relay_drive_b <= 1'b0;
      end else begin
         trip_irq              <= |(pend_q & en_q);
         test_relay_one_a      <= relay_q[0][rtd_pkg::RLY_T1];
         test_relay_one_b      <= relay_q[1][rtd_pkg::RLY_T1];
         test_relay_two_a      <= relay_q[0][rtd_pkg::RLY_T2];
         test_relay_two_b      <= relay_q[1][rtd_pkg::RLY_T2];
         ringing_relay_drive_a <= relay_q[0][rtd_pkg::RLY_RING];
         ringing_relay_drive_b <= relay_q[1][rtd_pkg::RLY_RING];
      end
   end
endmodule : rtd_top

// *** logic/rtd_pkg.sv ***
// ring trip detection: constants, register map and carrier types
// assumes a 125 MHz system clock and one AHB-Lite slave per block
// Function
// - debounce settings 16 bits, 1.25 ms steps
// - ac, dc thresholds and period 16 bits
// - high enough threshold never trips a path
// - trip pending flag with matching enable bit
// - read-only trip detected status bit
// - read-only 3-bit line state shadow
// - mask loop closure after ringing exit
// - ringing dc offset zero to 64.32 V
// - external ringing uses the same chain
// - test relays always, ringing relay variant only
// - samples processed only while ringing
// - debounce changes after full opposite interval
// - either path sets status, raises interrupt
// - ac path rectifies, dc path does not
package rtd_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PS      = 8000;     // 125 MHz period
   localparam int unsigned TICK_PS     = 1250000000;  // 1.25 ms step
   localparam int unsigned TICK_CYCLES = TICK_PS / CLK_PS;
   // ---------------------------------------------------------------
   // register map, word indices (haddr[5:2]) inside one channel window
   // ---------------------------------------------------------------
   localparam logic [3:0] IDX_AC_TH   = 4'h0;  // ac_trip_threshold
   localparam logic [3:0] IDX_DC_TH   = 4'h1;  // dc_trip_threshold
   localparam logic [3:0] IDX_PERIOD  = 4'h2;  // trip_sample_period
   localparam logic [3:0] IDX_AC_DB   = 4'h3;  // ac_trip_debounce
   localparam logic [3:0] IDX_DC_DB   = 4'h4;  // dc_trip_debounce
   localparam logic [3:0] IDX_SENSE   = 4'h5;  // loop_current_sense
   localparam logic [3:0] IDX_MASK    = 4'h6;  // closure_mask_time
   localparam logic [3:0] IDX_OFFSET  = 4'h7;  // ringing_dc_offset
   localparam logic [3:0] IDX_STATUS  = 4'h8;  // hook_trip_status_reg
   localparam logic [3:0] IDX_IRQVEC  = 4'h9;  // irq_vector_two
   localparam logic [3:0] IDX_IRQEN   = 4'ha;  // irq_enable_two
   localparam logic [3:0] IDX_RELAY   = 4'hb;  // relay drive control
   localparam int unsigned CH_BIT     = 6;     // haddr bit picking channel
   // field positions
   localparam int unsigned STS_TRIP   = 0;     // trip_detected
   localparam int unsigned STS_SHADOW = 4;     // line_state_shadow [6:4]
   localparam int unsigned IRQ_TRIP   = 0;     // trip pending / enable
   localparam int unsigned RLY_T1     = 0;     // test relay one
   localparam int unsigned RLY_T2     = 1;     // test relay two
   localparam int unsigned RLY_RING   = 2;     // ringing relay
   // reset values
   localparam logic [15:0] RST_TH     = 16'h7fff;
   localparam logic [15:0] RST_PERIOD = 16'h0028;
   localparam logic [15:0] RST_DB     = 16'h0010;
   localparam logic [7:0]  RST_MASK   = 8'h40;
   localparam logic [15:0] RST_OFFSET = 16'h0000;
   localparam logic [15:0] OFFSET_MAX = 16'h3333;  // 64.32 V code
   // line feed state that means ringing
   localparam logic [2:0]  LFS_RING   = 3'h4;
   // sample scaling before accumulation
   localparam int unsigned ACC_SHIFT  = 4;
   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] threshold;  // trip level
      logic [15:0] period;     // samples per filter window
      logic [15:0] debounce;   // ticks of 1.25 ms
   } rtd_path_cfg_s;
endpackage : rtd_pkg

// *** logic/rtd_tick.sv ***
// 1.25 ms enable pulse divider
// assumes hclk is the only clock
`timescale 1ns/1ps
module rtd_tick #(
   parameter int unsigned CYCLES = rtd_pkg::TICK_CYCLES
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   output logic      tick_q      // one-cycle pulse
);
   logic [31:0] cnt_q;           // cycles since last pulse

   // --------------------------------------------------------------
   // free-running divider
   // --------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q  <= 32'h0000_0000;
         tick_q <= 1'b0;
      end else if (cnt_q >= CYCLES - 1) begin
         cnt_q  <= 32'h0000_0000;
         tick_q <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 32'h0000_0001;
         tick_q <= 1'b0;
      end
   end
endmodule : rtd_tick

// *** logic/rtd_path.sv ***
// one detection path: rectifier, window filter, compare, debounce
// assumes samples arrive as single-cycle valid strobes
`timescale 1ns/1ps
module rtd_path (
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  run,      // line is ringing
   input  wire logic                  smp_vld,
   input  wire logic signed [15:0]    smp,
   input  wire logic                  rectify,
   input  wire rtd_pkg::rtd_path_cfg_s cfg,
   input  wire logic                  tick,
   output logic                       trip_q
);
   logic signed [39:0] acc_q;    // window sum
   logic [15:0]        n_q;      // samples in window
   logic               raw_q;    // compare result
   logic [15:0]        db_q;     // debounce ticks
   logic signed [16:0] x;        // conditioned sample
   logic signed [39:0] sum;      // sum including this sample
   logic [15:0]        lvl;      // saturated filter level

   // --------------------------------------------------------------
   // conditioning and saturation
   // --------------------------------------------------------------
   always_comb begin
      x = {smp[15], smp};
      if (rectify && smp[15]) begin
         x = -x;
      end
      sum = acc_q + 40'(x >>> rtd_pkg::ACC_SHIFT);
      if (sum < 0) begin
         lvl = 16'h0000;
      end else if (sum > 40'sh00_0000_ffff) begin
         lvl = 16'hffff;
      end else begin
         lvl = sum[15:0];
      end
   end

   // --------------------------------------------------------------
   // window filter and threshold; strict compare so a full-scale
   // threshold can never trip
   // --------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_q <= 40'sh00_0000_0000;
         n_q   <= 16'h0000;
         raw_q <= 1'b0;
      end else if (!run) begin
         acc_q <= 40'sh00_0000_0000;
         n_q   <= 16'h0000;
         raw_q <= 1'b0;
      end else if (smp_vld) begin
         if (n_q + 16'h0001 >= cfg.period) begin
            raw_q <= lvl > cfg.threshold;
            acc_q <= 40'sh00_0000_0000;
            n_q   <= 16'h0000;
         end else begin
            acc_q <= sum;
            n_q   <= n_q + 16'h0001;
         end
      end
   end

   // --------------------------------------------------------------
   // debounce: output moves only after the whole interval opposite
   // --------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         db_q   <= 16'h0000;
         trip_q <= 1'b0;
      end else if (!run) begin
         db_q   <= 16'h0000;
         trip_q <= 1'b0;
      end else if (raw_q == trip_q) begin
         db_q <= 16'h0000;
      end else if (tick) begin
         if (db_q >= cfg.debounce) begin
            trip_q <= raw_q;
            db_q   <= 16'h0000;
         end else begin
            db_q <= db_q + 16'h0001;
         end
      end
   end
endmodule : rtd_path

// *** tb/rtd_loop_model.sv ***
// loop side stand-in: line state plus paced current samples
// assumes the bench steers ringing, ac swing and dc level
`timescale 1ns/1ps
module rtd_loop_model (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               ring,
   input  wire logic signed [15:0] ac,
   input  wire logic signed [15:0] dc,
   output logic [1:0][15:0]        loop_current_sense,
   output logic [1:0]              sample_valid,
   output logic [1:0][2:0]         line_state
);
   logic [2:0]  ph_q;  // sample pacing, msb flips ac sign
   logic [15:0] v;     // current sample value
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) ph_q <= 3'h0;
      else ph_q <= ph_q + 3'h1;
   end
   assign v = dc + (ph_q[2] ? ac : -ac);
   assign sample_valid = {2{ph_q[1:0] == 2'h3}};
   // off the strobe the bus shows garbage, not the last value
   assign loop_current_sense = {2{sample_valid[0] ? v : ~v}};
   assign line_state = {2{ring ? 3'h4 : 3'h1}};
endmodule : rtd_loop_model

// *** tb/rtd_top_chk.sv ***
// port checker for rtd_top, bound at the foot of the file
// assumes one clock and single AHB-Lite word transfers
`timescale 1ns/1ps
module rtd_top_chk #(
   parameter int unsigned TICK_CYCLES = 20,
   parameter bit          EXT_RING    = 1'b1
) (
   input wire logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
   input wire logic trip_irq, test_relay_one_a, ringing_relay_drive_a,
   input wire logic [31:0] haddr, hwdata,
   input wire logic [1:0] htrans, closure_masked,
   input wire logic [1:0][2:0] line_state,
   input wire logic [1:0][15:0] ringing_dc_offset
);
   logic aph, wr_q, rly_q;   // address phase, write / relay data phase
   logic [2:0] wh_q;         // recent write data phases
   int unsigned mc_q;        // cycles closure mask has stood
   assign aph = hsel && hready && htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         rly_q <= 1'b0;
         wh_q <= 3'h0;
         mc_q <= 0;
      end else begin
         wr_q <= aph && hwrite;
         rly_q <= aph && hwrite && haddr == 32'h2c;
         wh_q <= {wh_q[1:0], wr_q};
         mc_q <= closure_masked[0] ? mc_q + 1 : 0;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   read_wait_a: assert property (aph && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   write_nowait_a: assert property (aph && hwrite |=> hreadyout)
      else $error("write stalled");
   resp_okay_a: assert property (hresp == 1'b0)
      else $error("error response");
   relay_follow_a: assert property (rly_q |-> ##2
      test_relay_one_a == $past(hwdata[0], 2)
      && ringing_relay_drive_a == ($past(hwdata[2], 2) && EXT_RING))
      else $error("relay drive wrong");
   mask_start_a: assert property ($rose(closure_masked[0]) |->
      $past(line_state[0]) == 3'h4 || $past(line_state[0], 2) == 3'h4
      || $past(line_state[0], 3) == 3'h4) else $error("mask without ringing exit");
   mask_len_a: assert property (mc_q <= 65 * TICK_CYCLES + 2)
      else $error("mask too long");
   offset_clamp_a: assert property (ringing_dc_offset[0] <= 16'h3333
      && ringing_dc_offset[1] <= 16'h3333) else $error("offset over range");
   irq_clear_a: assert property ($fell(trip_irq) |-> |wh_q)
      else $error("irq dropped unasked");
   cover property ($rose(trip_irq));
   cover property ($rose(closure_masked[0]));
   cover property (rly_q);
endmodule : rtd_top_chk
bind rtd_top rtd_top_chk #(.TICK_CYCLES(TICK_CYCLES), .EXT_RING(EXT_RING)) chk_i (
   .hclk, .hresetn, .hsel, .hwrite, .hready, .hreadyout, .hresp, .trip_irq,
   .test_relay_one_a, .ringing_relay_drive_a, .haddr, .hwdata, .htrans,
   .closure_masked, .line_state, .ringing_dc_offset);

// *** tb/tb_rtd_top.sv ***
// self-checking bench for rtd_top over AHB-Lite
// assumes rtd_loop_model drives the loop side
`timescale 1ns/1ps
module tb_rtd_top;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ring = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd_v;
   logic [1:0] htrans = 0, cm, sv;
   logic hreadyout, hresp, irq;
   logic [5:0] rl;  // {ring b, ring a, two b, two a, one b, one a}
   logic signed [15:0] ac = 0, dc = 0;
   logic [1:0][15:0] lcs, ofs;
   logic [1:0][2:0] ls;
   int error_cnt = 0, compares = 0, cyc = 0;
   rtd_loop_model lm (.hclk, .hresetn, .ring, .ac, .dc,
      .loop_current_sense(lcs), .sample_valid(sv), .line_state(ls));
   rtd_top #(.TICK_CYCLES(20)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
      .hresp, .loop_current_sense(lcs), .sample_valid(sv), .line_state(ls),
      .trip_irq(irq), .closure_masked(cm), .ringing_dc_offset(ofs),
      .test_relay_one_a(rl[0]), .test_relay_one_b(rl[1]), .test_relay_two_a(rl[2]),
      .test_relay_two_b(rl[3]), .ringing_relay_drive_a(rl[4]),
      .ringing_relay_drive_b(rl[5]));
   initial forever #4 hclk = ~hclk;
   // hang guard: the whole run needs well under 3000 cycles
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end
   end
   task automatic bus(input logic w, input logic [31:0] a, d);
      @(posedge hclk);
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd_v = hrdata;
   endtask : bus
   task automatic chk(input string n, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("FAIL %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic rd(input logic [31:0] a, e, input string n);
      bus(1'b0, a, 32'h0);
      chk(n, rd_v, e);
   endtask : rd
   task automatic wr(input logic [31:0] a, d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic t_regs;
      rd(32'h00, 32'h7fff, "ac_th");
      rd(32'h08, 32'h28, "period");
      rd(32'h18, 32'h40, "mask");
      wr(32'h10, 32'hffff);
      rd(32'h10, 32'hffff, "dc_db");
      wr(32'h1c, 32'hffff);
      rd(32'h1c, 32'h3333, "offset");
      wr(32'h20, 32'h1);
      rd(32'h20, 32'h10, "status");
      wr(32'h30, 32'h5);
      rd(32'h30, 32'h0, "unmapped");
   endtask : t_regs
   task automatic t_dc;
      wr(32'h08, 32'h1);
      wr(32'h0c, 32'h0);
      wr(32'h10, 32'h0);
      wr(32'h04, 32'h20);
      wr(32'h28, 32'h1);
      dc <= 16'sh0400;
      ring <= 1'b1;
      repeat (80) @(posedge hclk);
      rd(32'h20, 32'h41, "dc_trip");
      chk("irq", irq, 1'b1);
      ring <= 1'b0;
      repeat (4) @(posedge hclk);
      rd(32'h20, 32'h10, "restart");
      chk("masked", cm, 32'h3);
      rd(32'h24, 32'h1, "pending");
      wr(32'h24, 32'h1);
      repeat (3) @(posedge hclk);
      chk("irq_clr", irq, 1'b0);
   endtask : t_dc
   task automatic t_ac;
      {dc, ac} <= {16'sh0, 16'sh1000};
      wr(32'h04, 32'h7fff);
      wr(32'h00, 32'hdd);
      wr(32'h28, 32'h0);
      wr(32'h0c, 32'h2);
      ring <= 1'b1;
      repeat (30) @(posedge hclk);
      rd(32'h20, 32'h40, "debounce");
      repeat (100) @(posedge hclk);
      rd(32'h20, 32'h41, "ac_trip");
      chk("irq_off", irq, 1'b0);
      ring <= 1'b0;
   endtask : t_ac
   task automatic t_relay;
      wr(32'h2c, 32'h7);
      wr(32'h6c, 32'h2);
      repeat (3) @(posedge hclk);
      chk("relays", {26'h0, rl}, 32'h1d);
   endtask : t_relay
   task automatic results;
      if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : results
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_dc();
      t_ac();
      t_relay();
      results();
   end
endmodule : tb_rtd_top
